// ===== rtl/acr_pkg.sv
// package: register map, field layout and reset values of the clamp/config bank
package acr_pkg;
    localparam int          DATA_W          = 10;
    localparam int          REG_W           = 8;
    localparam int          ADDR_HI         = 9;
    localparam int          ADDR_LO         = 8;
    localparam logic [1:0]  ADDR_CLAMP_LOW  = 2'h0;
    localparam logic [1:0]  ADDR_CLAMP_HIGH = 2'h1;
    localparam logic [1:0]  ADDR_CONFIG     = 2'h2;
    localparam logic [1:0]  ADDR_RESERVED   = 2'h3;
    localparam logic [7:0]  RST_CLAMP_LOW   = 8'h00;
    localparam logic [7:0]  RST_CLAMP_HIGH  = 8'h00;
    localparam logic [7:0]  RST_CONFIG      = 8'h01;
    localparam int          GAIN_LSB        = 0;
    localparam int          GAIN_MSB        = 2;
    localparam int          POWER_DOWN_BIT_BIT        = 3;
    localparam int          CSRC_BIT        = 4;
    localparam int          SFMT_BIT        = 5;
    localparam int          CDIS_BIT        = 6;
    localparam int          CLH_MSB         = 1;
    localparam logic [9:0]  SIGN_FLIP       = 10'h200;
endpackage

// ===== rtl/acr_wr_if.sv
// interface: decoded write request between strobe detector and register bank
`timescale 1ns/1ps
interface acr_wr_if;
    logic       wr_pulse;
    logic [9:0] wr_word;
    modport src (output wr_pulse, output wr_word);
    modport dst (input wr_pulse, input wr_word);
endinterface

// ===== rtl/acr_strobe.sv
// module: write strobe edge detector for the shared data bus
`timescale 1ns/1ps
module acr_strobe (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wr_i,
    input  wire logic        oe_n_i,
    input  wire logic [9:0]  bus_i,
    acr_wr_if.src            wr
);
    logic       wr_q,   wr_d;
    logic [9:0] word_q, word_d;
    logic       pls_q,  pls_d;

    // ===================================================
    // strobe capture
    // data held while strobe high; latch on falling edge
    always_comb begin
        wr_d   = wr_i;
        word_d = (wr_i && oe_n_i) ? bus_i : word_q;
        pls_d  = wr_q && !wr_i && oe_n_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q   <= 1'b0;
            word_q <= 10'h000;
            pls_q  <= 1'b0;
        end else if (ce_i) begin
            wr_q   <= wr_d;
            word_q <= word_d;
            pls_q  <= pls_d;
        end
    end

    assign wr.wr_pulse = pls_q;
    assign wr.wr_word  = word_q;
endmodule

// ===== rtl/acr_top.sv
// module: write-only clamp level and conversion configuration register bank
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
(
    input  wire logic                      MCLK_I,
    input  wire logic                      RST_I,
    input  wire logic                      CE_I,
    input  wire logic                      WR_I,
    input  wire logic                      OE_N_I,
    input  wire logic [acr_pkg::DATA_W-1:0] BUS_I,
    input  wire logic [acr_pkg::DATA_W-1:0] RESULT_I,
    input  wire logic                      OVER_RANGE_I,
    output logic      [acr_pkg::DATA_W-1:0] BUS_O,
    output logic      [acr_pkg::DATA_W-1:0] BUS_OE_O,
    output logic                           OVER_RANGE_FLAG_O,
    output logic                           OVER_RANGE_FLAG_OE_O,
    output logic      [2:0]                GAIN_SELECT_O,
    output logic                           POWER_DOWN_BIT_O,
    output logic                           CLAMP_SOURCE_SELECT_O,
    output logic                           SIGNED_FORMAT_BIT_O,
    output logic                           CLAMP_OUT_DISABLE_O,
    output logic      [9:0]                CLAMP_LEVEL_CODE_O
);
    import acr_pkg::*;

    acr_wr_if wr ();

    // ===================================================
    // register state
    logic [7:0] clamp_low_q,  clamp_low_d;
    logic [7:0] clamp_high_q, clamp_high_d;
    logic [7:0] config_q,     config_d;
    logic       sel_low,      sel_high;
    logic       sel_cfg;

    // ===================================================
    // result bus state
    logic [9:0] bus_q,        bus_d;
    logic [9:0] bus_oe_q,     bus_oe_d;
    logic       ovr_q,        ovr_d;
    logic       ovr_oe_q,     ovr_oe_d;

    // ===================================================
    // helpers
    // format conversion: flipping msb maps 0..1023 onto -512..511
    function automatic logic [9:0] fmt_result(input logic [9:0] raw, input logic twos);
        fmt_result = twos ? (raw ^ SIGN_FLIP) : raw;
    endfunction

    // slot match on the two address bits
    function automatic logic slot_hit(input logic [9:0] word, input logic [1:0] slot);
        slot_hit = (word[ADDR_HI:ADDR_LO] == slot);
    endfunction

    // every data pin shares one enable
    function automatic logic [9:0] pin_enable(input logic drive);
        pin_enable = drive ? 10'h3ff : 10'h000;
    endfunction

    // ===================================================
    // write strobe capture
    acr_strobe u_strobe (
        .clk_i  (MCLK_I),
        .rst_i  (RST_I),
        .ce_i   (CE_I),
        .wr_i   (WR_I),
        .oe_n_i (OE_N_I),
        .bus_i  (BUS_I),
        .wr     (wr)
    );

    // ===================================================
    // address decode
    // decode only on the pulse cycle; the word is held stable upstream
    always_comb begin
        sel_low  = wr.wr_pulse && slot_hit(wr.wr_word, ADDR_CLAMP_LOW);
        sel_high = wr.wr_pulse && slot_hit(wr.wr_word, ADDR_CLAMP_HIGH);
        sel_cfg  = wr.wr_pulse && slot_hit(wr.wr_word, ADDR_CONFIG);
        // slot 11 selects nothing, so all registers keep their value
    end

    // ===================================================
    // clamp level low byte
    always_comb begin
        clamp_low_d = clamp_low_q;
        if (sel_low) begin
            clamp_low_d = wr.wr_word[REG_W-1:0];
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            clamp_low_q <= RST_CLAMP_LOW;
        end else if (CE_I) begin
            clamp_low_q <= clamp_low_d;
        end
    end

    // ===================================================
    // clamp level high bits
    // upper six bits have no function and are stored as zero
    always_comb begin
        clamp_high_d = clamp_high_q;
        if (sel_high) begin
            clamp_high_d = {6'h00, wr.wr_word[CLH_MSB:0]};
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            clamp_high_q <= RST_CLAMP_HIGH;
        end else if (CE_I) begin
            clamp_high_q <= clamp_high_d;
        end
    end

    // ===================================================
    // conversion configuration
    // bit 7 is unused and stored as zero
    always_comb begin
        config_d = config_q;
        if (sel_cfg) begin
            config_d = {1'b0, wr.wr_word[CDIS_BIT:0]};
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            config_q <= RST_CONFIG;
        end else if (CE_I) begin
            config_q <= config_d;
        end
    end

    // ===================================================
    // result word and over-range
    // no register readback path: bus only carries conversion results
    always_comb begin
        bus_d = fmt_result(RESULT_I, config_q[SFMT_BIT]);
        ovr_d = OVER_RANGE_I;
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            bus_q <= 10'h000;
            ovr_q <= 1'b0;
        end else if (CE_I) begin
            bus_q <= bus_d;
            ovr_q <= ovr_d;
        end
    end

    // ===================================================
    // output enables
    // registered like the data so pins turn around on one edge
    always_comb begin
        bus_oe_d = pin_enable(!OE_N_I);
        ovr_oe_d = !OE_N_I;
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            // pins released while in reset
            bus_oe_q <= 10'h000;
            ovr_oe_q <= 1'b0;
        end else if (CE_I) begin
            bus_oe_q <= bus_oe_d;
            ovr_oe_q <= ovr_oe_d;
        end
    end

    // ===================================================
    // outputs straight from flops
    // result word and flag, config fields and clamp level code
    assign BUS_O                 = bus_q;
    assign BUS_OE_O              = bus_oe_q;
    assign OVER_RANGE_FLAG_O     = ovr_q;
    assign OVER_RANGE_FLAG_OE_O  = ovr_oe_q;
    assign GAIN_SELECT_O         = config_q[GAIN_MSB:GAIN_LSB];
    assign POWER_DOWN_BIT_O      = config_q[POWER_DOWN_BIT_BIT];
    assign CLAMP_SOURCE_SELECT_O = config_q[CSRC_BIT];
    assign SIGNED_FORMAT_BIT_O   = config_q[SFMT_BIT];
    assign CLAMP_OUT_DISABLE_O   = config_q[CDIS_BIT];
    assign CLAMP_LEVEL_CODE_O    = {clamp_high_q[CLH_MSB:0], clamp_low_q};
endmodule

// ===== tb/acr_monitor.sv
// checker: port-level assertions of the clamp and config register bank
`timescale 1ns/1ps
module acr_monitor (
    input wire logic       MCLK_I, RST_I, CE_I, WR_I, OE_N_I, OVER_RANGE_I,
    input wire logic [9:0] BUS_I, RESULT_I, BUS_O, BUS_OE_O, CLAMP_LEVEL_CODE_O,
    input wire logic       OVER_RANGE_FLAG_O, OVER_RANGE_FLAG_OE_O, POWER_DOWN_BIT_O,
    input wire logic       CLAMP_SOURCE_SELECT_O, SIGNED_FORMAT_BIT_O, CLAMP_OUT_DISABLE_O,
    input wire logic [2:0] GAIN_SELECT_O
);
    logic [6:0] cfg;
    assign cfg = {CLAMP_OUT_DISABLE_O, SIGNED_FORMAT_BIT_O, CLAMP_SOURCE_SELECT_O,
                  POWER_DOWN_BIT_O, GAIN_SELECT_O};
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // a strobe fall with the bus as input and the clock enabled is one write
    sequence s_wr; CE_I && WR_I && OE_N_I ##1 CE_I && !WR_I; endsequence
    property p_rst; $fell(RST_I) |-> cfg == 7'h01 && CLAMP_LEVEL_CODE_O == 10'h000; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_cfg; (s_wr ##0 $past(BUS_I[9:8]) == 2'h2) |-> ##2 cfg == $past(BUS_I[6:0], 3);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config write lost");
    property p_lo; (s_wr ##0 $past(BUS_I[9:8]) == 2'h0)
        |-> ##2 CLAMP_LEVEL_CODE_O[7:0] == $past(BUS_I[7:0], 3); endproperty
    a_lo: assert property (p_lo) else $error("clamp low write lost");
    property p_hi; (s_wr ##0 $past(BUS_I[9:8]) == 2'h1)
        |-> ##2 CLAMP_LEVEL_CODE_O[9:8] == $past(BUS_I[1:0], 3); endproperty
    a_hi: assert property (p_hi) else $error("clamp high write lost");
    property p_rsvd; (s_wr ##0 $past(BUS_I[9:8]) == 2'h3) |-> ##2
        CLAMP_LEVEL_CODE_O == $past(CLAMP_LEVEL_CODE_O, 3) && cfg == $past(cfg, 3); endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved write took effect");
    property p_drv; CE_I && !OE_N_I |=> BUS_OE_O == 10'h3ff && OVER_RANGE_FLAG_OE_O; endproperty
    a_drv: assert property (p_drv) else $error("bus not driven");
    property p_tri; CE_I && OE_N_I |=> BUS_OE_O == 10'h000 && !OVER_RANGE_FLAG_OE_O; endproperty
    a_tri: assert property (p_tri) else $error("bus not released");
    property p_dat; CE_I && !OE_N_I |=> OVER_RANGE_FLAG_O == $past(OVER_RANGE_I)
        && BUS_O == ($past(RESULT_I) ^ {$past(SIGNED_FORMAT_BIT_O), 9'h000}); endproperty
    a_dat: assert property (p_dat) else $error("result word wrong");
    c_wr: cover property (s_wr);
    c_rsvd: cover property (s_wr ##0 $past(BUS_I[9:8]) == 2'h3);
    c_sgn: cover property (!OE_N_I && SIGNED_FORMAT_BIT_O);
endmodule
bind acr_top acr_monitor u_mon (.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I), .WR_I(WR_I),
    .OE_N_I(OE_N_I), .OVER_RANGE_I(OVER_RANGE_I), .BUS_I(BUS_I), .RESULT_I(RESULT_I),
    .BUS_O(BUS_O), .BUS_OE_O(BUS_OE_O), .CLAMP_LEVEL_CODE_O(CLAMP_LEVEL_CODE_O),
    .OVER_RANGE_FLAG_O(OVER_RANGE_FLAG_O), .OVER_RANGE_FLAG_OE_O(OVER_RANGE_FLAG_OE_O),
    .POWER_DOWN_BIT_O(POWER_DOWN_BIT_O), .CLAMP_SOURCE_SELECT_O(CLAMP_SOURCE_SELECT_O),
    .SIGNED_FORMAT_BIT_O(SIGNED_FORMAT_BIT_O), .CLAMP_OUT_DISABLE_O(CLAMP_OUT_DISABLE_O),
    .GAIN_SELECT_O(GAIN_SELECT_O));

// ===== tb/acr_host.sv
// host model: drives strobe, output-enable and the shared bus
`timescale 1ns/1ps
module acr_host (
    input  wire logic       clk_i,
    output logic            wr_o,
    output logic            oe_n_o,
    output logic [9:0]      bus_o
);
    initial begin
        wr_o = 1'b0;
        oe_n_o = 1'b1;
        bus_o = 10'h155;
    end
    // word held over strobe, slot 11 only when told
    task automatic put(input logic [9:0] w);
        @(negedge clk_i);
        oe_n_o = 1'b1;
        bus_o = w;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        @(negedge clk_i);
        // released bus shows the inverse, never the stale word
        bus_o = ~w;
    endtask
    task automatic look(input logic oe_n);
        @(negedge clk_i);
        oe_n_o = oe_n;
    endtask
endmodule

// ===== tb/tb_adc_clamp_pga_config_registers.sv
// testbench: register writes, reserved slot, result bus and reset values
`timescale 1ns/1ps
module tb_adc_clamp_pga_config_registers;
    logic       MCLK_I = 1'b0, RST_I = 1'b1, orng = 1'b0, wr, oe_n, ofl, ofl_oe, pd, cs, sf, cd;
    logic       ce = 1'b1;
    logic [9:0] res = 10'h000, bus, bo, boe, code, cfg;
    logic [2:0] gs;
    int         err_total = 0, checks_done = 0, cycles = 0;
    assign cfg = {3'h0, cd, sf, cs, pd, gs};
    always #25 MCLK_I = ~MCLK_I;
    acr_host u_host (.clk_i(MCLK_I), .wr_o(wr), .oe_n_o(oe_n), .bus_o(bus));
    acr_top u_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(ce), .WR_I(wr), .OE_N_I(oe_n),
        .BUS_I(bus), .RESULT_I(res), .OVER_RANGE_I(orng), .BUS_O(bo), .BUS_OE_O(boe),
        .OVER_RANGE_FLAG_O(ofl), .OVER_RANGE_FLAG_OE_O(ofl_oe), .GAIN_SELECT_O(gs),
        .POWER_DOWN_BIT_O(pd), .CLAMP_SOURCE_SELECT_O(cs), .SIGNED_FORMAT_BIT_O(sf),
        .CLAMP_OUT_DISABLE_O(cd), .CLAMP_LEVEL_CODE_O(code));
    task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset();
        @(negedge MCLK_I);
        RST_I = 1'b1;
        repeat (12) @(negedge MCLK_I);
        RST_I = 1'b0;
        @(negedge MCLK_I);
        cmp("config", 10'h001, cfg);
        cmp("clamp code", 10'h000, code);
    endtask
    // multiples of 37 give all eight gain codes and mixed flags
    task automatic t_config();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 8'(i * 37);
            u_host.put({2'h2, d});
            repeat (3) @(negedge MCLK_I);
            cmp("config", {3'h0, d[6:0]}, cfg);
        end
    endtask
    task automatic t_clamp();
        u_host.put(10'h00f);
        u_host.put(10'h101);
        repeat (3) @(negedge MCLK_I);
        cmp("clamp code", 10'h10f, code);
        u_host.put(10'h3ff);
        repeat (3) @(negedge MCLK_I);
        cmp("clamp code", 10'h10f, code);
        cmp("config", 10'h003, cfg);
    endtask
    task automatic t_read();
        u_host.look(1'b0);
        res = 10'h3ff;
        orng = 1'b1;
        repeat (2) @(negedge MCLK_I);
        cmp("bus drive", 10'h3ff, boe);
        cmp("bus data", 10'h3ff, bo);
        cmp("over range", 10'h001, {9'h0, ofl});
        u_host.put(10'h221);
        repeat (3) @(negedge MCLK_I);
        u_host.look(1'b0);
        res = 10'h000;
        repeat (2) @(negedge MCLK_I);
        cmp("bus data", 10'h200, bo);
        u_host.look(1'b1);
        repeat (2) @(negedge MCLK_I);
        cmp("bus drive", 10'h000, boe);
        cmp("over range drive", 10'h000, {9'h0, ofl_oe});
    endtask
    // enable low freezes strobe, registers and pins
    task automatic t_freeze();
        u_host.look(1'b0);
        res = 10'h0aa;
        orng = 1'b0;
        repeat (2) @(negedge MCLK_I);
        cmp("bus data", 10'h2aa, bo);
        cmp("over range", 10'h000, {9'h0, ofl});
        ce = 1'b0;
        res = 10'h155;
        orng = 1'b1;
        u_host.put(10'h208);
        repeat (3) @(negedge MCLK_I);
        cmp("frozen bus data", 10'h2aa, bo);
        cmp("frozen bus drive", 10'h3ff, boe);
        cmp("frozen over range", 10'h000, {9'h0, ofl});
        ce = 1'b1;
        repeat (3) @(negedge MCLK_I);
        cmp("bus drive", 10'h000, boe);
        cmp("config", 10'h021, cfg);
    endtask
    // ceiling well above the roughly 120 cycles the run needs
    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        t_reset();
        t_config();
        t_clamp();
        t_read();
        t_freeze();
        t_reset();
        stop_test();
    end
endmodule
